// ==== design/ivsu_defs.svh ====
`ifndef IVSU_DEFS_SVH
`define IVSU_DEFS_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define APB_AW 18

// ----------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------
`define IDX_PEND_MID 16'hFE05
`define IDX_PEND_HIGH 16'hFE06
`define IDX_EVT_STATUS 16'h0100
`define IDX_EVT_MASK 16'h0101
`define IDX_SRC_ENABLE 16'h0102
`define IDX_VEC_SEL 16'h0103

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PEND 16'h0000
`define RST_EVT 3'h0
`define RST_ENABLE 16'hFFFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define EVT_NEW_PEND 0
`define EVT_VEC_TAKEN 1
`define EVT_RO_WRITE 2
`define EVT_W 3
`define FLAG_RESERVED 6
`define PEND_MID_LSB 6
`define PEND_HIGH_LSB 14

// ----------------------------------------
// vector addresses (high byte; low byte follows)
// ----------------------------------------
`define VEC_TIMEBASE 16'hFFDC
`define VEC_CONV_DONE 16'hFFDE
`define VEC_KEYPAD 16'hFFE0
`define VEC_ASYNC_TX 16'hFFE2
`define VEC_ASYNC_RX 16'hFFE4
`define VEC_ASYNC_ERR 16'hFFE6
`define VEC_SYNC_TX 16'hFFE8
`define VEC_SYNC_RX 16'hFFEA
`define VEC_TIMER_B_OVF 16'hFFEC
`define VEC_RESERVED 16'hFFEE
`define VEC_TIMER_B_CH0 16'hFFF0
`define VEC_TIMER_A_OVF 16'hFFF2
`define VEC_TIMER_A_CH1 16'hFFF4
`define VEC_TIMER_A_CH0 16'hFFF6
`define VEC_SYNTH 16'hFFF8
`define VEC_EXT_PIN 16'hFFFA
`define VEC_SOFTWARE_TRAP 16'hFFFC
`define VEC_RESET 16'hFFFE

`endif

// ==== design/ivsu_pkg.sv ====
package ivsu_pkg;
   typedef logic [15:0] flags_t;
   typedef logic [15:0] vec_addr_t;
   typedef logic [4:0] flag_idx_t;
   typedef enum logic [1:0] {
      ST_BOOT = 2'b01,
      ST_RUN = 2'b10
   } boot_state_e;
endpackage : ivsu_pkg

// ==== design/irq_vec_if.sv ====
`timescale 1ns/1ps
interface irq_vec_if;
   import ivsu_pkg::*;
   flags_t pending;
   flags_t enable;
   logic sel_valid;
   flag_idx_t sel_idx;
   vec_addr_t sel_addr;
   modport bank (output pending);
   modport arb (input pending, input enable, output sel_valid,
      output sel_idx, output sel_addr);
   modport ctrl (input pending, input sel_valid, input sel_idx,
      input sel_addr, output enable);
endinterface : irq_vec_if

// ==== design/pending_bank.sv ====
`timescale 1ns/1ps
`include "ivsu_defs.svh"
module pending_bank (
   input wire logic pclk,
   input wire logic presetn,
   input ivsu_pkg::flags_t src_req,
   irq_vec_if.bank bus
);
   import ivsu_pkg::*;

   flags_t pend_r;

   // ----------------------------------------
   // one flag per source, index i is flag i+1
   // ----------------------------------------
   for (genvar i = 0; i < 16; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pend_r[i] <= 1'b0;
         end else if (i == `FLAG_RESERVED) begin
            pend_r[i] <= 1'b0; // [R7]
         end else begin
            pend_r[i] <= src_req[i]; // [R15]
         end
      end
   end

   assign bus.pending = pend_r;
endmodule : pending_bank

// ==== design/vector_arbiter.sv ====
`timescale 1ns/1ps
`include "ivsu_defs.svh"
module vector_arbiter (
   irq_vec_if.arb bus
);
   import ivsu_pkg::*;

   flags_t en_pend;
   flag_idx_t idx;
   logic found;

   assign en_pend = bus.pending & bus.enable;

   // ----------------------------------------
   // higher vector address wins, so flag 1 beats flag 16
   // ----------------------------------------
   always_comb begin
      idx = 5'h00;
      found = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (en_pend[i]) begin
            idx = 5'(i + 1); // [R14]
            found = 1'b1;
         end
      end
   end

   always_comb begin
      case (idx)
         5'h10: bus.sel_addr = `VEC_TIMEBASE; // [R15]
         5'h0F: bus.sel_addr = `VEC_CONV_DONE; // [R1]
         5'h0E: bus.sel_addr = `VEC_KEYPAD; // [R15]
         5'h0D: bus.sel_addr = `VEC_ASYNC_TX; // [R2]
         5'h0C: bus.sel_addr = `VEC_ASYNC_RX; // [R3]
         5'h0B: bus.sel_addr = `VEC_ASYNC_ERR; // [R4]
         5'h0A: bus.sel_addr = `VEC_SYNC_TX; // [R5]
         5'h09: bus.sel_addr = `VEC_SYNC_RX; // [R6]
         5'h08: bus.sel_addr = `VEC_TIMER_B_OVF; // [R7]
         5'h07: bus.sel_addr = `VEC_RESERVED; // [R7]
         5'h06: bus.sel_addr = `VEC_TIMER_B_CH0; // [R8]
         5'h05: bus.sel_addr = `VEC_TIMER_A_OVF; // [R9]
         5'h04: bus.sel_addr = `VEC_TIMER_A_CH1; // [R10]
         5'h03: bus.sel_addr = `VEC_TIMER_A_CH0; // [R11]
         5'h02: bus.sel_addr = `VEC_SYNTH; // [R15]
         5'h01: bus.sel_addr = `VEC_EXT_PIN; // [R15]
         default: bus.sel_addr = `VEC_RESET;
      endcase
   end

   assign bus.sel_idx = idx;
   assign bus.sel_valid = found;
endmodule : vector_arbiter

// ==== design/interrupt_vector_status_unit.sv ====
`timescale 1ns/1ps
`include "ivsu_defs.svh"
// What this block does
// R1: conversion-done (flag 15) vectors through FFDE/FFDF.
// R2: async transmit (flag 13) vectors through FFE2/FFE3.
// R3: async receive (flag 12) vectors through FFE4/FFE5.
// R4: async error (flag 11) vectors through FFE6/FFE7.
// R5: sync transmit (flag 10) vectors through FFE8/FFE9.
// R6: sync receive (flag 9) vectors through FFEA/FFEB.
// R7: timer b overflow (flag 8) uses FFEC/FFED; flag 7 at FFEE is reserved.
// R8: timer b channel 0 (flag 6) vectors through FFF0/FFF1.
// R9: timer a overflow (flag 5) vectors through FFF2/FFF3.
// R10: timer a channel 1 (flag 4) vectors through FFF4/FFF5.
// R11: timer a channel 0 (flag 3) vectors through FFF6/FFF7.
// R12: flags 14..7 read as bits 7..0 at FE05, read-only, zero at reset.
// R13: flags 16,15 read as bits 1,0 at FE06, rest zero, read-only.
// R14: higher vector address means higher priority, reset on top.
// R15: timebase 16, keypad 14, synth 2, ext pin 1; trap and reset unflagged.
module interrupt_vector_status_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input ivsu_pkg::flags_t src_req,
   input wire logic sw_trap_req,
   input wire logic cpu_vec_fetch,
   output logic cpu_irq,
   output ivsu_pkg::vec_addr_t cpu_vec_addr,
   output logic cpu_vec_valid,
   output logic irq
);
   import ivsu_pkg::*;

   irq_vec_if vif ();

   pending_bank u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .src_req(src_req),
      .bus(vif.bank)
   );

   vector_arbiter u_arb (
      .bus(vif.arb)
   );

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic setup;
   logic access;
   logic hit;
   logic wr_en;
   logic [15:0] idx;
   logic [31:0] rd_nxt;
   logic [31:0] prdata_r;

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign idx = paddr[`APB_AW-1:2];

   always_comb begin
      hit = 1'b0;
      if (paddr[1:0] == 2'h0) begin
         case (idx)
            `IDX_PEND_MID,
            `IDX_PEND_HIGH,
            `IDX_EVT_STATUS,
            `IDX_EVT_MASK,
            `IDX_SRC_ENABLE,
            `IDX_VEC_SEL: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
   end

   assign wr_en = access & pwrite & hit;
   assign pready = access;
   assign pslverr = access & ~hit;

   // ----------------------------------------
   // control and event registers
   // ----------------------------------------
   logic [`EVT_W-1:0] evt_status_r;
   logic [`EVT_W-1:0] evt_mask_r;
   logic [`EVT_W-1:0] evt_set;
   logic [`EVT_W-1:0] evt_clr;
   flags_t enable_r;
   flags_t pend_q_r;
   logic ro_write;

   assign vif.enable = enable_r;
   // flag registers ignore writes; the attempt is only logged
   assign ro_write = wr_en & ((idx == `IDX_PEND_MID) |
      (idx == `IDX_PEND_HIGH)); // [R12] [R13]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_r <= `RST_ENABLE;
      end else if (wr_en && idx == `IDX_SRC_ENABLE) begin
         if (pstrb[0]) enable_r[7:0] <= pwdata[7:0];
         if (pstrb[1]) enable_r[15:8] <= pwdata[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_mask_r <= `RST_EVT;
      end else if (wr_en && idx == `IDX_EVT_MASK && pstrb[0]) begin
         evt_mask_r <= pwdata[`EVT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q_r <= `RST_PEND;
      end else begin
         pend_q_r <= vif.pending;
      end
   end

   always_comb begin
      evt_set = `RST_EVT;
      evt_set[`EVT_NEW_PEND] = |(vif.pending & ~pend_q_r);
      evt_set[`EVT_VEC_TAKEN] = cpu_vec_fetch;
      evt_set[`EVT_RO_WRITE] = ro_write;
      evt_clr = `RST_EVT;
      if (wr_en && idx == `IDX_EVT_STATUS && pstrb[0]) begin
         evt_clr = pwdata[`EVT_W-1:0];
      end
   end

   // set beats clear so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_status_r <= `RST_EVT;
      end else begin
         evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
      end
   end

   assign irq = |(evt_status_r & evt_mask_r);

   // ----------------------------------------
   // read path, sampled in the setup cycle
   // ----------------------------------------
   always_comb begin
      rd_nxt = 32'h0;
      case (idx)
         `IDX_PEND_MID:
            rd_nxt = {24'h0, vif.pending[`PEND_MID_LSB +: 8]}; // [R12]
         `IDX_PEND_HIGH:
            rd_nxt = {30'h0, vif.pending[`PEND_HIGH_LSB +: 2]}; // [R13]
         `IDX_EVT_STATUS: rd_nxt = {29'h0, evt_status_r};
         `IDX_EVT_MASK: rd_nxt = {29'h0, evt_mask_r};
         `IDX_SRC_ENABLE: rd_nxt = {16'h0, enable_r};
         `IDX_VEC_SEL: rd_nxt = {15'h0, vif.sel_valid, vif.sel_addr};
         default: rd_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (setup && !pwrite) begin
         prdata_r <= hit ? rd_nxt : 32'h0;
      end
   end

   assign prdata = prdata_r;

   // ----------------------------------------
   // cpu vector fetch
   // ----------------------------------------
   boot_state_e boot_r;
   vec_addr_t vec_addr_r;
   logic vec_valid_r;

   assign cpu_irq = vif.sel_valid | sw_trap_req;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_r <= ST_BOOT;
         vec_addr_r <= `VEC_RESET;
         vec_valid_r <= 1'b0;
      end else begin
         vec_valid_r <= cpu_vec_fetch;
         if (cpu_vec_fetch) begin
            case (boot_r)
               ST_BOOT: begin
                  vec_addr_r <= `VEC_RESET; // [R14]
                  boot_r <= ST_RUN;
               end
               ST_RUN: begin
                  if (sw_trap_req) begin
                     vec_addr_r <= `VEC_SOFTWARE_TRAP; // [R14] [R15]
                  end else if (vif.sel_valid) begin
                     vec_addr_r <= vif.sel_addr; // [R14]
                  end else begin
                     vec_addr_r <= `VEC_RESET;
                  end
               end
               default: boot_r <= ST_BOOT;
            endcase
         end
      end
   end

   assign cpu_vec_addr = vec_addr_r;
   assign cpu_vec_valid = vec_valid_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   flags_t en_pend;
   flags_t win;
   logic low_busy;
   logic svc;

   assign en_pend = vif.pending & enable_r;
   assign svc = cpu_vec_fetch & (boot_r == ST_RUN) & ~sw_trap_req;

   always_comb begin
      low_busy = 1'b0;
      win = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         win[i] = en_pend[i] & ~low_busy;
         low_busy = low_busy | en_pend[i];
      end
   end

   property p_r1;
      @(posedge pclk) disable iff (!presetn)
      svc && win[14] |=> cpu_vec_valid && cpu_vec_addr == 16'hFFDE;
   endproperty
   a_r1: assert property (p_r1) else $error("conversion vector wrong"); // [R1]

   property p_r2;
      @(posedge pclk) disable iff (!presetn)
      svc && win[12] |=> cpu_vec_addr == 16'hFFE2;
   endproperty
   a_r2: assert property (p_r2) else $error("async tx vector wrong"); // [R2]

   property p_r3;
      @(posedge pclk) disable iff (!presetn)
      svc && win[11] |=> cpu_vec_addr == 16'hFFE4;
   endproperty
   a_r3: assert property (p_r3) else $error("async rx vector wrong"); // [R3]

   property p_r4;
      @(posedge pclk) disable iff (!presetn)
      svc && win[10] |=> cpu_vec_addr == 16'hFFE6;
   endproperty
   a_r4: assert property (p_r4) else $error("async err vector wrong"); // [R4]

   property p_r5;
      @(posedge pclk) disable iff (!presetn)
      svc && win[9] |=> cpu_vec_addr == 16'hFFE8;
   endproperty
   a_r5: assert property (p_r5) else $error("sync tx vector wrong"); // [R5]

   property p_r6;
      @(posedge pclk) disable iff (!presetn)
      svc && win[8] |=> cpu_vec_addr == 16'hFFEA;
   endproperty
   a_r6: assert property (p_r6) else $error("sync rx vector wrong"); // [R6]

   property p_r7;
      @(posedge pclk) disable iff (!presetn)
      svc && win[7] |=> cpu_vec_addr == 16'hFFEC;
   endproperty
   a_r7: assert property (p_r7) else $error("timer b ovf wrong"); // [R7]

   property p_r7_rsv;
      @(posedge pclk) disable iff (!presetn)
      src_req[6] |=> !vif.pending[6];
   endproperty
   a_r7_rsv: assert property (p_r7_rsv) else $error("flag 7 set"); // [R7]

   property p_r8;
      @(posedge pclk) disable iff (!presetn)
      svc && win[5] |=> cpu_vec_addr == 16'hFFF0;
   endproperty
   a_r8: assert property (p_r8) else $error("timer b ch0 wrong"); // [R8]

   property p_r9;
      @(posedge pclk) disable iff (!presetn)
      svc && win[4] |=> cpu_vec_addr == 16'hFFF2;
   endproperty
   a_r9: assert property (p_r9) else $error("timer a ovf wrong"); // [R9]

   property p_r10;
      @(posedge pclk) disable iff (!presetn)
      svc && win[3] |=> cpu_vec_addr == 16'hFFF4;
   endproperty
   a_r10: assert property (p_r10) else $error("timer a ch1 wrong"); // [R10]

   property p_r11;
      @(posedge pclk) disable iff (!presetn)
      svc && win[2] |=> cpu_vec_addr == 16'hFFF6;
   endproperty
   a_r11: assert property (p_r11) else $error("timer a ch0 wrong"); // [R11]

   property p_r12;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && idx == 16'hFE05 && paddr[1:0] == 2'h0
      |=> prdata == {24'h0, $past(vif.pending[13:6])};
   endproperty
   a_r12: assert property (p_r12) else $error("mid flags misread"); // [R12]

   property p_r13;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && idx == 16'hFE06 && paddr[1:0] == 2'h0
      |=> prdata[31:2] == 30'h0 && prdata[1:0] == $past(vif.pending[15:14]);
   endproperty
   a_r13: assert property (p_r13) else $error("high flags misread"); // [R13]

   property p_r14;
      @(posedge pclk) disable iff (!presetn)
      svc && en_pend[0] && en_pend[15] |=> cpu_vec_addr == 16'hFFFA;
   endproperty
   a_r14: assert property (p_r14) else $error("priority wrong"); // [R14]

   property p_r15;
      @(posedge pclk) disable iff (!presetn)
      cpu_vec_fetch && boot_r == ST_RUN && sw_trap_req
      |=> cpu_vec_valid ##0 cpu_vec_addr == 16'hFFFC;
   endproperty
   a_r15: assert property (p_r15) else $error("trap vector wrong"); // [R15]
endmodule : interrupt_vector_status_unit

// ==== bench/cpu_src_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// cpu core and peripheral request lines
// ----------------------------------------
module cpu_src_model (
   input wire logic pclk,
   output ivsu_pkg::flags_t src_req,
   output logic sw_trap_req,
   output logic cpu_vec_fetch,
   input wire logic cpu_vec_valid,
   input ivsu_pkg::vec_addr_t cpu_vec_addr
);
   import ivsu_pkg::*;

   initial begin
      src_req = 16'h0000;
      sw_trap_req = 1'b0;
      cpu_vec_fetch = 1'b0;
   end

   // two quiet edges so the flags have landed before any fetch
   task set_src(input flags_t v, input logic trap);
      @(posedge pclk);
      src_req <= v;
      sw_trap_req <= trap;
      repeat (2) @(posedge pclk);
   endtask : set_src

   // one-cycle pulse; answer awaited under a bound, never assumed
   task fetch(output vec_addr_t a, output logic ok);
      int k;
      ok = 1'b0;
      a = 16'h0000;
      @(posedge pclk);
      cpu_vec_fetch <= 1'b1;
      @(posedge pclk);
      cpu_vec_fetch <= 1'b0;
      for (k = 0; k < 4 && !ok; k++) begin
         if (cpu_vec_valid === 1'b1) begin
            ok = 1'b1;
            a = cpu_vec_addr;
         end else begin
            @(posedge pclk);
         end
      end
   endtask : fetch
endmodule : cpu_src_model

// ==== bench/interrupt_vector_status_unit_tb.sv ====
`timescale 1ns/1ps
`include "ivsu_defs.svh"
module interrupt_vector_status_unit_tb;
   import ivsu_pkg::*;
   logic pclk, presetn, psel, penable, pwrite;
   logic [`APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic pready, pslverr, sw_trap_req, cpu_vec_fetch;
   logic cpu_irq, cpu_vec_valid, irq;
   flags_t src_req;
   vec_addr_t cpu_vec_addr;
   int n_mismatch, tests_run;

   interrupt_vector_status_unit i_interrupt_vector_status_unit (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_req(src_req), .sw_trap_req(sw_trap_req),
      .cpu_vec_fetch(cpu_vec_fetch), .cpu_irq(cpu_irq),
      .cpu_vec_addr(cpu_vec_addr), .cpu_vec_valid(cpu_vec_valid),
      .irq(irq));

   cpu_src_model i_cpu_src_model (
      .pclk(pclk), .src_req(src_req), .sw_trap_req(sw_trap_req),
      .cpu_vec_fetch(cpu_vec_fetch), .cpu_vec_valid(cpu_vec_valid),
      .cpu_vec_addr(cpu_vec_addr));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task check(input string what, input logic [31:0] seen,
              input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 16) check("pready", 32'h0, 32'h1);
   endtask : apb

   task vfetch(input string what, input logic [15:0] exp);
      vec_addr_t a;
      logic ok;
      i_cpu_src_model.fetch(a, ok);
      check(what, {ok, 15'h0000, a}, {1'b1, 15'h0000, exp});
   endtask : vfetch

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      logic [31:0] r;
      logic e;
      apb(1'b0, `IDX_PEND_MID, 32'h0, r, e);
      check("mid_rst", r, 32'h0);
      apb(1'b0, `IDX_PEND_HIGH, 32'h0, r, e);
      check("high_rst", r, 32'h0);
      apb(1'b0, `IDX_SRC_ENABLE, 32'h0, r, e);
      check("enable_rst", r, 32'h0000FFFF);
      vfetch("boot_vec", 16'hFFFE);
      $display("test reset done");
   endtask : t_reset

   // reserved flag 7 alone must look like no request at all
   task t_vectors;
      logic [15:0] e;
      int n;
      for (n = 1; n <= 16; n++) begin
         i_cpu_src_model.set_src(flags_t'(1) << (n - 1), 1'b0);
         e = (n == 7) ? 16'hFFFE : 16'(32'hFFFC - 2 * n);
         vfetch("vec", e);
         check("cpu_irq", {31'h0, cpu_irq}, {31'h0, n != 7});
      end
      i_cpu_src_model.set_src(16'h0000, 1'b0);
      $display("test vectors done");
   endtask : t_vectors

   task t_priority;
      logic [31:0] r;
      logic e;
      i_cpu_src_model.set_src(16'hFFFF, 1'b0);
      vfetch("prio_all", 16'hFFFA);
      i_cpu_src_model.set_src(16'hFFFF, 1'b1);
      vfetch("prio_trap", 16'hFFFC);
      i_cpu_src_model.set_src(16'hFFFF, 1'b0);
      apb(1'b1, `IDX_SRC_ENABLE, 32'h0000FFFE, r, e);
      vfetch("prio_no1", 16'hFFF8);
      apb(1'b1, `IDX_SRC_ENABLE, 32'h00008000, r, e);
      vfetch("prio_tb", 16'hFFDC);
      apb(1'b1, `IDX_SRC_ENABLE, 32'h0000FFFF, r, e);
      i_cpu_src_model.set_src(16'h0000, 1'b0);
      $display("test priority done");
   endtask : t_priority

   // writes to the flag mirrors are dropped but leave an event behind
   task t_status;
      flags_t p[2];
      logic [31:0] r;
      logic e;
      int i;
      p[0] = 16'hA5C3;
      p[1] = 16'h5A3C;
      for (i = 0; i < 2; i++) begin
         i_cpu_src_model.set_src(p[i], 1'b0);
         apb(1'b0, `IDX_PEND_MID, 32'h0, r, e);
         check("mid", r, {24'h0, p[i][13:7], 1'b0});
         apb(1'b0, `IDX_PEND_HIGH, 32'h0, r, e);
         check("high", r, {30'h0, p[i][15:14]});
      end
      apb(1'b1, `IDX_EVT_MASK, 32'h4, r, e);
      apb(1'b1, `IDX_PEND_MID, 32'hFF, r, e);
      check("ro_err", {31'h0, e}, 32'h0);
      apb(1'b1, `IDX_PEND_HIGH, 32'hFF, r, e);
      apb(1'b0, `IDX_PEND_MID, 32'h0, r, e);
      check("mid_ro", r, {24'h0, p[1][13:7], 1'b0});
      apb(1'b0, `IDX_PEND_HIGH, 32'h0, r, e);
      check("high_ro", r, {30'h0, p[1][15:14]});
      check("irq_set", {31'h0, irq}, 32'h1);
      apb(1'b0, `IDX_VEC_SEL, 32'h0, r, e);
      check("vec_sel", r, 32'h0001FFF6);
      apb(1'b0, `IDX_EVT_MASK, 32'h0, r, e);
      check("evt_mask", r, 32'h4);
      apb(1'b0, `IDX_EVT_STATUS, 32'h0, r, e);
      check("evt_all", r, 32'h7);
      apb(1'b1, `IDX_EVT_STATUS, 32'h4, r, e);
      repeat (2) @(posedge pclk);
      check("irq_clr", {31'h0, irq}, 32'h0);
      apb(1'b0, `IDX_EVT_STATUS, 32'h0, r, e);
      check("evt_w1c", r, 32'h3);
      apb(1'b0, 16'h0002, 32'h0, r, e);
      check("unmapped", {e, r[30:0]}, 32'h80000000);
      i_cpu_src_model.set_src(16'h0000, 1'b0);
      $display("test status done");
   endtask : t_status

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_vectors;
      t_priority;
      t_status;
      conclude;
   end

   // whole run is well under two thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      conclude;
   end
endmodule : interrupt_vector_status_unit_tb
